/* stc_pkg.sv */
/*
 * shared constants and types of the serial port transfer control block.
 * assumes a 125 MHz pclk and a 32-bit APB master in the same domain.
 */
package stc_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_TX   = 12'h004;
	localparam logic [11:0] ADDR_RX   = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00c;

	localparam int B_EN    = 0;
	localparam int B_ROLE  = 1;
	localparam int B_PHASE = 2;
	localparam int B_IDLE  = 3;
	localparam int B_OD    = 4;
	localparam int B_LSB   = 5;
	localparam int B_TRIG  = 6;
	localparam int B_ZFILL = 7;
	localparam int B_RXFL  = 12;
	localparam int B_TXFL  = 13;

	localparam logic [13:0] CTRL_MASK = 14'h30ff;
	localparam logic [13:0] CTRL_RST  = 14'h0000;
	localparam logic [7:0]  FILL_BYTE = 8'h00;

	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS  = 32;
	localparam int HALF_CYC      = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [3:0] LAST_BIT  = 4'h7;

	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_GAP   = 3'b100
	} stc_state_type;

	typedef struct packed {
		logic sclk;
		logic ss_n;
		logic mosi;
		logic miso;
	} stc_pins_type;

	localparam stc_pins_type PINS_RST = '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};

	typedef struct packed {
		logic [13:0]   ctrl;
		stc_state_type state;
		logic [7:0]    tx_sh;
		logic [7:0]    rx_sh;
		logic [7:0]    last_tx;
		logic [7:0]    rx_data;
		logic          rx_full;
		logic          rd_pend;
		logic [3:0]    bit_cnt;
		logic [7:0]    div;
		logic          half;
		stc_pins_type  pin_meta;
		stc_pins_type  pin_sync;
		stc_pins_type  pin_last;
		logic          sclk_o;
		logic          sclk_oe;
		logic          ss_n_o;
		logic          ss_n_oe;
		logic          mosi_o;
		logic          mosi_oe;
		logic          miso_o;
		logic          miso_oe;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		logic          irq;
	} stc_regs_type;

	localparam stc_regs_type REGS_RST = '{
		ctrl: CTRL_RST, state: ST_IDLE, tx_sh: 8'h00, rx_sh: 8'h00, last_tx: 8'h00,
		rx_data: 8'h00, rx_full: 1'b0, rd_pend: 1'b0, bit_cnt: 4'h0, div: 8'h00,
		half: 1'b0, pin_meta: PINS_RST, pin_sync: PINS_RST, pin_last: PINS_RST,
		sclk_o: 1'b0, sclk_oe: 1'b0, ss_n_o: 1'b1, ss_n_oe: 1'b0, mosi_o: 1'b0,
		mosi_oe: 1'b0, miso_o: 1'b0, miso_oe: 1'b0, pready: 1'b0, pslverr: 1'b0,
		prdata: 32'h0000_0000, irq: 1'b0};
endpackage : stc_pkg

/* stc_fifo.sv */
/*
 * transmit queue: synchronous FIFO with valid/ready on both sides.
 * assumes push and pop share pclk; flush empties it and refuses pushes.
 */
module stc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} stc_fifo_state_type;

	stc_fifo_state_type r;
	stc_fifo_state_type n;
	logic               push;
	logic               pop;

	assign in_ready  = !flush && (r.cnt != (AW+1)'(DEPTH));
	assign out_valid = !flush && (r.cnt != '0);
	assign out_data  = r.mem[r.rp];

	always_comb
	begin
		n    = r;
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		if (flush)
		begin
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
		end
		else
		begin
			if (push)
			begin
				n.mem[r.wp] = in_data;
				n.wp        = r.wp + 1'b1;
			end
			if (pop)
				n.rp = r.rp + 1'b1;
			if (push && !pop)
				n.cnt = r.cnt + 1'b1;
			else if (pop && !push)
				n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end
endmodule : stc_fifo

/* stc_core.sv */
/*
 * serial peripheral port with APB control, a 16-byte transmit queue and
 * a one-byte receive holding register; acts as bus controller or target.
 * assumes an APB master on pclk; pin inputs are asynchronous and are
 * double-registered here; the board resolves pin levels from the enables.
 */
module stc_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe,
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_n_oe,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	output logic             port_irq
);
	stc_pkg::stc_regs_type r;
	stc_pkg::stc_regs_type n;
	stc_pkg::stc_pins_type pins_in;
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [7:0]            fifo_out_data;
	logic                  load_now;
	logic                  done;
	logic [7:0]            done_byte;
	logic [7:0]            fill;
	logic [7:0]            rx_shifted;
	logic [7:0]            tx_shifted;
	logic                  sdi;
	logic                  sclk_edge;
	logic                  lead;
	logic                  trail;
	logic                  samp_t;
	logic                  shft_t;
	logic                  access;
	logic                  out_bit;
	logic                  drive;
	logic                  en;
	logic                  role;
	logic                  phase;
	logic                  idle_lvl;
	logic                  lsb;
	logic                  trig;
	logic                  txfl;
	logic                  rxfl;
	logic                  od;

	assign pins_in = '{sclk: sclk_in, ss_n: ss_n_in, mosi: mosi_in, miso: miso_in};
	assign en       = r.ctrl[stc_pkg::B_EN];
	assign role     = r.ctrl[stc_pkg::B_ROLE];
	assign phase    = r.ctrl[stc_pkg::B_PHASE];
	assign idle_lvl = r.ctrl[stc_pkg::B_IDLE];
	assign lsb      = r.ctrl[stc_pkg::B_LSB];
	assign trig     = r.ctrl[stc_pkg::B_TRIG];
	assign txfl     = r.ctrl[stc_pkg::B_TXFL];
	assign rxfl     = r.ctrl[stc_pkg::B_RXFL];
	assign od       = r.ctrl[stc_pkg::B_OD];

	// a full queue stalls the APB write through pready, so nothing is lost
	stc_fifo #(
		.WIDTH (stc_pkg::BYTE_W),
		.DEPTH (stc_pkg::FIFO_DEPTH)
	) u_txq (
		.pclk      (pclk),
		.presetn   (presetn),
		.flush     (txfl),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pwdata[7:0]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	always_comb
	begin
		n              = r;
		load_now       = 1'b0;
		done           = 1'b0;
		fifo_in_valid  = 1'b0;
		fifo_out_ready = 1'b0;
		n.pready       = 1'b0;
		n.pslverr      = 1'b0;
		n.pin_meta     = pins_in;
		n.pin_sync     = r.pin_meta;
		n.pin_last     = r.pin_sync;
		// queue held in flush counts as empty for the fill choice
		fill = (fifo_out_valid && !txfl) ? fifo_out_data :
			(r.ctrl[stc_pkg::B_ZFILL] ? stc_pkg::FILL_BYTE : r.last_tx);
		sdi        = role ? r.pin_sync.miso : r.pin_sync.mosi;
		rx_shifted = lsb ? {sdi, r.rx_sh[7:1]} : {r.rx_sh[6:0], sdi};
		tx_shifted = lsb ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0};
		sclk_edge  = r.pin_sync.sclk ^ r.pin_last.sclk;
		lead       = sclk_edge && (r.pin_sync.sclk != idle_lvl);
		trail      = sclk_edge && (r.pin_sync.sclk == idle_lvl);
		samp_t     = phase ? trail : lead;
		shft_t     = phase ? lead : trail;
		done_byte  = role ? r.rx_sh : rx_shifted;

		if (!en)
		begin
			n.state   = stc_pkg::ST_IDLE;
			n.rd_pend = 1'b0;
			n.ss_n_o  = 1'b1;
		end
		else
		begin
			case (r.state)
				stc_pkg::ST_IDLE:
				begin
					n.bit_cnt = 4'h0;
					n.div     = 8'h00;
					n.half    = 1'b0;
					if ((role && (trig ? (fifo_out_valid && !txfl) : r.rd_pend)) ||
						(!role && !r.pin_sync.ss_n && r.pin_last.ss_n))
					begin
						load_now       = 1'b1;
						fifo_out_ready = !txfl;
						n.tx_sh        = fill;
						n.last_tx      = fill;
						n.rd_pend      = 1'b0;
						n.ss_n_o       = !role;
						n.state        = stc_pkg::ST_SHIFT;
					end
				end
				stc_pkg::ST_SHIFT:
				begin
					if (role)
					begin
						n.div = r.div + 8'h01;
						if (r.div == stc_pkg::HALF_LAST)
						begin
							n.div  = 8'h00;
							n.half = !r.half;
							if (!r.half)
								n.rx_sh = rx_shifted;
							else
							begin
								n.bit_cnt = r.bit_cnt + 4'h1;
								if (r.bit_cnt == stc_pkg::LAST_BIT)
								begin
									done     = 1'b1;
									n.ss_n_o = 1'b1;
									n.state  = stc_pkg::ST_GAP;
								end
								else
									n.tx_sh = tx_shifted;
							end
						end
					end
					else if (r.pin_sync.ss_n)
						n.state = stc_pkg::ST_IDLE;
					else
					begin
						if (samp_t)
						begin
							n.rx_sh   = rx_shifted;
							n.bit_cnt = r.bit_cnt + 4'h1;
							if (r.bit_cnt == stc_pkg::LAST_BIT)
							begin
								done    = 1'b1;
								n.state = stc_pkg::ST_GAP;
							end
						end
						// with the pulse at bit start the first leading edge only
						// launches the byte already presented
						if (shft_t && (!phase || r.bit_cnt != 4'h0))
							n.tx_sh = tx_shifted;
					end
				end
				stc_pkg::ST_GAP:
				begin
					if (role)
					begin
						n.div = r.div + 8'h01;
						if (r.div == stc_pkg::HALF_LAST)
							n.state = stc_pkg::ST_IDLE;
					end
					else if (r.pin_sync.ss_n)
						n.state = stc_pkg::ST_IDLE;
				end
				default:
					n.state = stc_pkg::ST_IDLE;
			endcase
		end

		access = psel && penable && !r.pready;
		if (access)
		begin
			n.pready = 1'b1;
			case (paddr)
				stc_pkg::ADDR_CTRL:
				begin
					n.prdata = {18'h00000, r.ctrl};
					if (pwrite)
						n.ctrl = pwdata[13:0] & stc_pkg::CTRL_MASK;
				end
				stc_pkg::ADDR_TX:
				begin
					n.prdata = 32'h0000_0000;
					if (pwrite && !txfl)
					begin
						fifo_in_valid = 1'b1;
						n.pready      = fifo_in_ready;
					end
				end
				stc_pkg::ADDR_RX:
				begin
					n.prdata = {24'h000000, r.rx_data};
					if (!pwrite)
					begin
						n.rx_full = 1'b0;
						if (!trig && en)
							n.rd_pend = 1'b1;
					end
				end
				stc_pkg::ADDR_STAT:
					n.prdata = {28'h0000000, !fifo_in_ready, !fifo_out_valid, r.rx_full,
						r.state != stc_pkg::ST_IDLE};
				default:
				begin
					n.prdata  = 32'h0000_0000;
					n.pslverr = 1'b1;
				end
			endcase
		end

		// a byte that lands in the cycle of a read still sets the flag
		if (done && !rxfl)
		begin
			n.rx_data = done_byte;
			n.rx_full = 1'b1;
		end

		n.sclk_o = (n.ctrl[stc_pkg::B_ROLE] && n.state == stc_pkg::ST_SHIFT) ?
			(n.ctrl[stc_pkg::B_IDLE] ^ (n.ctrl[stc_pkg::B_PHASE] ? !n.half : n.half)) :
			n.ctrl[stc_pkg::B_IDLE];
		n.sclk_oe = n.ctrl[stc_pkg::B_EN] && n.ctrl[stc_pkg::B_ROLE];
		n.ss_n_oe = n.sclk_oe;
		out_bit   = n.ctrl[stc_pkg::B_LSB] ? n.tx_sh[0] : n.tx_sh[7];
		drive     = n.ctrl[stc_pkg::B_EN] && n.state == stc_pkg::ST_SHIFT;
		// open drain only ever pulls low; a one is left to the pull-up
		n.mosi_o  = n.ctrl[stc_pkg::B_OD] ? 1'b0 : out_bit;
		n.mosi_oe = drive && n.ctrl[stc_pkg::B_ROLE] && (!n.ctrl[stc_pkg::B_OD] || !out_bit);
		n.miso_o  = n.mosi_o;
		n.miso_oe = drive && !n.ctrl[stc_pkg::B_ROLE] && (!n.ctrl[stc_pkg::B_OD] || !out_bit);
		n.irq = n.ctrl[stc_pkg::B_EN] && !n.ctrl[stc_pkg::B_RXFL] && (n.ctrl[stc_pkg::B_TRIG] ?
			(!fifo_out_valid && n.state == stc_pkg::ST_IDLE) : n.rx_full);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= stc_pkg::REGS_RST;
		else
			r <= n;
	end

	assign pready   = r.pready;
	assign prdata   = r.prdata;
	assign pslverr  = r.pslverr;
	assign sclk_out = r.sclk_o;
	assign sclk_oe  = r.sclk_oe;
	assign ss_n_out = r.ss_n_o;
	assign ss_n_oe  = r.ss_n_oe;
	assign mosi_out = r.mosi_o;
	assign mosi_oe  = r.mosi_oe;
	assign miso_out = r.miso_o;
	assign miso_oe  = r.miso_oe;
	assign port_irq = r.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ZERO_FILL: assert property (load_now && (!fifo_out_valid || txfl) && r.ctrl[stc_pkg::B_ZFILL]
		|=> r.last_tx == 8'h00 && r.tx_sh == 8'h00) else $error("zero fill not sent");
	AST_REPEAT_LAST: assert property (load_now && (!fifo_out_valid || txfl) && !r.ctrl[stc_pkg::B_ZFILL]
		|=> $stable(r.last_tx) && r.tx_sh == r.last_tx) else $error("last byte not resent");
	AST_WRITE_START: assert property (r.state == stc_pkg::ST_IDLE && en && role && trig && fifo_out_valid
		&& !txfl |=> r.state == stc_pkg::ST_SHIFT && !ss_n_out) else $error("write did not start");
	AST_READ_START: assert property (access && paddr == stc_pkg::ADDR_RX && !pwrite && !trig && en && role
		&& r.state == stc_pkg::ST_IDLE |=> ##1 r.state == stc_pkg::ST_SHIFT) else $error("read did not start");
	AST_BIT_ORDER: assert property (load_now && role && !od |=> mosi_out == (lsb ? r.tx_sh[0] : r.tx_sh[7]))
		else $error("first bit order wrong");
	AST_OPEN_DRAIN: assert property (od |-> !(mosi_oe && mosi_out) && !(miso_oe && miso_out))
		else $error("open drain drove high");
	AST_IDLE_LEVEL: assert property (r.state != stc_pkg::ST_SHIFT |-> sclk_out == idle_lvl)
		else $error("clock idle level wrong");
	AST_PHASE: assert property (role && r.state == stc_pkg::ST_SHIFT |-> sclk_out == (idle_lvl ^ (phase ?
		!r.half : r.half))) else $error("clock pulse misplaced");
	AST_TARGET_NO_CLK: assert property (!role |-> !sclk_oe && !ss_n_oe && !mosi_oe)
		else $error("target drove controller pins");
	AST_DISABLE: assert property (!en |=> r.state == stc_pkg::ST_IDLE && !mosi_oe && !miso_oe)
		else $error("disabled port still active");
	AST_TX_FLUSH: assert property (txfl |-> !fifo_in_valid && !fifo_out_ready)
		else $error("queue used during flush");
	AST_RX_FLUSH: assert property (done && rxfl |=> $stable(r.rx_data) && !port_irq)
		else $error("flushed byte kept");
	AST_TARGET_START: assert property (en && !role && r.state == stc_pkg::ST_IDLE
		&& !r.pin_sync.ss_n && r.pin_last.ss_n |=> r.state == stc_pkg::ST_SHIFT && ss_n_out)
		else $error("target did not start on select");
	// a byte landing in the cycle of a receive read must still leave the flag set
	AST_RX_SET_WINS: assert property (done && !rxfl |=> r.rx_full && r.rx_data == $past(done_byte))
		else $error("received byte not held");
	AST_READ_IRQ: assert property (en && !trig && !rxfl |-> port_irq == r.rx_full)
		else $error("receive interrupt wrong");
endmodule : stc_core

/* stc_peer.sv */
/*
 * external serial target standing at the far side of the port.
 * assumes it sees the resolved clock, select and data lines and is told
 * the clock idle level and phase in use; it replies with a byte given by the bench.
 */
module stc_peer (
	input  wire logic        sclk,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	input  wire logic        idle,
	input  wire logic        phase,
	input  wire logic [7:0]  reply,
	output logic             miso,
	output logic      [7:0]  got,
	output int unsigned      n_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int         nsamp;
	logic [7:0] sh;

	initial
	begin
		miso = 1'b0;
		got = 8'h00;
		n_done = 0;
		nsamp = 0;
		sh = 8'h00;
	end

	// first reply bit stands ready before the first sampling clock edge
	always @(negedge ss_n)
		miso = reply[7];

	// edges are told apart by the level they reach, not by counting, so a clock
	// edge that lands together with a select change can not shift the frame
	always @(posedge sclk or negedge sclk)
	begin
		if (!ss_n)
		begin
			if (sclk == (idle ^ !phase))
			begin
				sh = {sh[6:0], mosi};
				nsamp = nsamp + 1;
			end
			else if (nsamp > 0 && nsamp < 8)
				miso = reply[3'(7 - nsamp)];
		end
	end

	// released line shows the inverse of the last bit, not a held value
	always @(posedge ss_n)
	begin
		if (nsamp == 8)
		begin
			got = sh;
			n_done = n_done + 1;
		end
		nsamp = 0;
		miso = ~miso;
	end
endmodule : stc_peer

/* tb_spi_transfer_control.sv */
/*
 * self-checking bench of the serial port transfer control block.
 * assumes an APB master on pclk and the peer model on the serial lines.
 */
module tb_spi_transfer_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [13:0] EN   = 14'h0001;
	localparam logic [13:0] ROLE = 14'h0002;
	localparam logic [13:0] OD   = 14'h0010;
	localparam logic [13:0] TRIG = 14'h0040;
	localparam logic [13:0] ZF   = 14'h0080;
	localparam logic [13:0] RXFL = 14'h1000;
	localparam logic [13:0] TXFL = 14'h2000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, port_irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        sclk_out, sclk_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
	logic [7:0]  rep_byte, peer_got, txb, lastb;
	logic [13:0] ctl;
	logic        ext_sclk, ext_ss_n, ext_mosi;
	logic [7:0]  ext_rx;
	int unsigned peer_done, n0;
	int          num_errors, checks_done, cyc, drv_hi;
	// board: pull-ups on select and data out, pull-down on the clock; the bench
	// holds those levels and drives the lines itself when it plays the controller
	wire         sclk_line = sclk_oe ? sclk_out : ext_sclk;
	wire         ss_line   = ss_n_oe ? ss_n_out : ext_ss_n;
	wire         mosi_line = mosi_oe ? mosi_out : ext_mosi;
	wire         miso_line = miso_oe ? miso_out : peer_miso;

	stc_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ss_n_in(ss_line),
		.ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .mosi_in(mosi_line), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_line), .miso_out(miso_out), .miso_oe(miso_oe),
		.port_irq(port_irq));

	stc_peer u_peer (.sclk(sclk_line), .ss_n(ss_line), .mosi(mosi_line), .idle(ctl[stc_pkg::B_IDLE]),
		.phase(ctl[stc_pkg::B_PHASE]), .reply(rep_byte), .miso(peer_miso), .got(peer_got), .n_done(peer_done));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc++;
		if (mosi_oe && mosi_out)
			drv_hi++;
		if (cyc == 20000)
		begin
			num_errors++;
			conclude();
		end
	end

	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction : rev8

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// holds the request until pready is seen; never assumes a latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n < 100), 32'h1);
	endtask : apb

	// one byte: queue write, plus a receive read when reads start transfers
	task automatic run_byte(input logic [13:0] c, input logic [7:0] tx);
		int n;
		ctl = c;
		apb(1'b1, stc_pkg::ADDR_CTRL, {18'h0, c});
		repeat (3) @(posedge pclk);
		chk(32'({sclk_oe, sclk_out}), {30'h0, 1'b1, c[stc_pkg::B_IDLE]});
		n0 = peer_done;
		apb(1'b1, stc_pkg::ADDR_TX, {24'h0, tx});
		if (!c[stc_pkg::B_TRIG])
			apb(1'b0, stc_pkg::ADDR_RX, 32'h0);
		n = 0;
		while (peer_done == n0 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n < 400), 32'h1);
		n = 0;
		do
		begin
			apb(1'b0, stc_pkg::ADDR_STAT, 32'h0);
			n++;
		end
		while (rdv[0] !== 1'b0 && n < 20);
		chk(32'(rdv[0]), 32'h0);
	endtask : run_byte

	// bench as outside controller of a target port: 80 ns clock, idle low, phase 0, msb first
	task automatic ext_byte(input logic [7:0] tx, output logic [7:0] rx);
		ext_ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			ext_mosi <= tx[i];
			repeat (5) @(posedge pclk);
			rx[i] = miso_line;
			ext_sclk <= 1'b1;
			repeat (5) @(posedge pclk);
			ext_sclk <= 1'b0;
		end
		repeat (5) @(posedge pclk);
		ext_ss_n <= 1'b1;
		ext_mosi <= 1'b1;
		repeat (5) @(posedge pclk);
	endtask : ext_byte

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rep_byte = 8'h00;
		ctl = 14'h0;
		ext_sclk = 1'b0;
		ext_ss_n = 1'b1;
		ext_mosi = 1'b1;
		num_errors = 0;
		checks_done = 0;
		cyc = 0;
		drv_hi = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, stc_pkg::ADDR_CTRL, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, stc_pkg::ADDR_STAT, 32'h0);
		chk(rdv, 32'h4);
		apb(1'b0, 12'h010, 32'h0);
		chk({rdv[30:0], err}, 32'h1);
		// every combination of bit order, idle level and phase
		for (int m = 0; m < 8; m++)
		begin
			txb = 8'h1d + 8'(m * 37);
			rep_byte = 8'h6b + 8'(m * 19);
			run_byte(EN | ROLE | TRIG | 14'(m[0]) << 5 | 14'(m[1]) << 3 | 14'(m[2]) << 2, txb);
			chk(32'(peer_got), 32'(m[0] ? rev8(txb) : txb));
			chk(32'(port_irq), 32'h1);
			apb(1'b0, stc_pkg::ADDR_RX, 32'h0);
			chk(rdv, 32'(m[0] ? rev8(rep_byte) : rep_byte));
			lastb = txb;
		end
		chk(32'(drv_hi > 0), 32'h1);
		run_byte(EN | ROLE | TXFL, 8'h5a);
		chk(32'(peer_got), 32'(lastb));
		run_byte(EN | ROLE | TXFL | ZF, 8'h5a);
		chk(32'(peer_got), 32'(stc_pkg::FILL_BYTE));
		chk(32'(port_irq), 32'h1);
		run_byte(EN | ROLE | RXFL, 8'h3c);
		apb(1'b0, stc_pkg::ADDR_STAT, 32'h0);
		chk(32'({port_irq, rdv[1]}), 32'h0);
		drv_hi = 0;
		run_byte(EN | ROLE | TRIG | OD, 8'h96);
		chk(32'(peer_got), 32'h96);
		chk(32'(drv_hi), 32'h0);
		// disabled port must not start even with a queued byte
		apb(1'b1, stc_pkg::ADDR_CTRL, {18'h0, ROLE | TRIG});
		n0 = peer_done;
		apb(1'b1, stc_pkg::ADDR_TX, 32'h11);
		repeat (200) @(posedge pclk);
		chk(32'({sclk_oe, ss_n_oe}), 32'h0);
		chk(peer_done, n0);
		apb(1'b1, stc_pkg::ADDR_CTRL, {18'h0, EN | TRIG});
		repeat (10) @(posedge pclk);
		chk(32'({sclk_oe, ss_n_oe}), 32'h0);
		chk(peer_done, n0);
		chk(32'(port_irq), 32'h0);
		ext_byte(8'hc3, ext_rx);
		chk(32'(ext_rx), 32'h11);
		chk(32'(port_irq), 32'h1);
		apb(1'b0, stc_pkg::ADDR_RX, 32'h0);
		chk(rdv, 32'hc3);
		conclude();
	end
endmodule : tb_spi_transfer_control
